// >>> rtl/oms_core.sv
// oscillator mode decode, output pin mux, pll gating and start-up hold
`timescale 1ns/1ps
module oms_core
    import oms_pkg::*;
#(
    parameter logic [23:0] MODE_MAP  = oms_pkg::OMS_MAP_DEF,  // 3 bits per code
    parameter int unsigned PLL_LOCK_TIMEOUT_CYC  = oms_pkg::OMS_PLL_LOCK_TIMEOUT_CYC, // pll lock wait
    parameter int unsigned EC_CYC    = oms_pkg::OMS_EC_CYC    // ext clock start
) (
    input  wire logic                            clk_i,          // system clock
    input  wire logic                            rst_i,          // power-on reset
    input  wire logic [oms_pkg::OMS_SEL_W-1:0]   osc_sel_field_i,// programmed field
    input  wire logic                            wake_i,         // wake from sleep pulse
    input  wire logic                            sec_osc_sel_i,  // running on secondary osc
    input  wire logic                            port_a_bit6_i,  // port a bit 6 out value
    input  wire logic                            port_a_bit6_oe_i,// port a bit 6 drive
    output logic                                 osc_out_pin_o,  // output pin value
    output logic                                 osc_out_pin_oe_o,// output pin enable
    output logic                                 port_a_bit6_o,  // pin read back
    output logic                                 feedback_en_o,  // feedback device on
    output logic                                 pll_en_o,       // pll engaged, x4
    output logic                                 exec_hold_o,    // hold execution
    output logic [7:0]                           mode_o          // decoded one-hot mode
);
    import oms_pkg::*;

    localparam int unsigned TW = 24;
    // elaboration check: both waits must fit the shared down counter
    if (PLL_LOCK_TIMEOUT_CYC >= (1 << TW) || EC_CYC >= (1 << TW) || EC_CYC < 1) begin : g_bad_count
        $error("oms_core: timer count out of range");
    end

    // map a field code to its mode through the parameter table
    function automatic oms_mode_type oms_decode(input logic [OMS_SEL_W-1:0] code);
        logic [2:0] idx;
        idx = MODE_MAP[code*3 +: 3];
        oms_decode = oms_mode_type'(8'h01 << idx);
    endfunction : oms_decode

    // mode latched once after reset release; never reloaded while running
    logic         cap_q,  cap_d;
    oms_mode_type mode_q, mode_d;
    logic         pll_q,  pll_d;
    logic         sec_q,  sec_d;
    logic [1:0]   div_q,  div_d;
    logic         out_q,  out_d;
    logic         start_q, start_d;

    always_comb begin
        cap_d   = 1'b1;
        mode_d  = mode_q;
        pll_d   = pll_q;
        sec_d   = sec_osc_sel_i;
        start_d = 1'b0;
        if (!cap_q) begin
            mode_d  = oms_decode(osc_sel_field_i);
            start_d = 1'b1;
        end
        // pll only follows mode at capture or on return from secondary osc
        if (!cap_q || (sec_q && !sec_osc_sel_i)) begin
            // after capture only the latched mode counts, so a reprogrammed field cannot steer the pll
            pll_d = cap_q ? (mode_q == OMS_HSX4) : (oms_decode(osc_sel_field_i) == OMS_HSX4);
            if (cap_q) begin
                start_d = 1'b1;
            end
        end
        if (sec_osc_sel_i) begin
            pll_d = 1'b0;
        end
    end

    // divide by four of the oscillator for the output pin
    always_comb begin
        div_d = div_q + 2'h1;
        out_d = div_q[1];
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cap_q   <= 1'b0;
            mode_q  <= OMS_LP;
            pll_q   <= 1'b0;
            sec_q   <= 1'b0;
            div_q   <= OMS_DIV_RST;
            out_q   <= 1'b0;
            start_q <= 1'b0;
        end else begin
            cap_q   <= cap_d;
            mode_q  <= mode_d;
            pll_q   <= pll_d;
            sec_q   <= sec_d;
            div_q   <= div_d;
            out_q   <= out_d;
            start_q <= start_d;
        end
    end

    // start-up wait: pll lock time or external clock start-up
    logic          ext_mode;
    logic          load;
    logic [TW-1:0] wait_cnt;
    logic          busy;

    assign ext_mode = (mode_q == OMS_EC) || (mode_q == OMS_EXT_CLOCK_GPIO_MODE);
    assign load     = (start_q && (pll_q || ext_mode)) || (wake_i && ext_mode);
    assign wait_cnt = pll_q ? TW'(PLL_LOCK_TIMEOUT_CYC) : TW'(EC_CYC);

    oms_timer #(
        .WIDTH (TW)
    ) u_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .load_i  (load),
        .count_i (wait_cnt),
        .busy_o  (busy)
    );

    // pin and enable outputs
    always_comb begin
        osc_out_pin_o    = 1'b0;
        osc_out_pin_oe_o = 1'b0;
        feedback_en_o    = 1'b0;
        case (mode_q)
            OMS_LP, OMS_XT, OMS_HS, OMS_HSX4: begin
                feedback_en_o = cap_q;
            end
            OMS_RC, OMS_EC: begin
                osc_out_pin_o    = out_q;
                osc_out_pin_oe_o = cap_q;
            end
            OMS_RC_NETWORK_GPIO_MODE, OMS_EXT_CLOCK_GPIO_MODE: begin
                osc_out_pin_o    = port_a_bit6_i;
                osc_out_pin_oe_o = port_a_bit6_oe_i;
            end
            default: begin
                osc_out_pin_o = 1'b0;
            end
        endcase
        // external clock modes keep feedback off via the default above
    end

    assign port_a_bit6_o = osc_out_pin_o;
    assign pll_en_o      = pll_q;
    assign exec_hold_o   = !cap_q || start_q || busy;
    assign mode_o        = mode_q;
endmodule : oms_core

// >>> rtl/oms_pkg.sv
// constants and types for the oscillator mode select block
// Notes on behaviour
// - eight clock modes chosen by a three-bit programmed configuration field.
// - mode field is fixed at programming; running logic cannot change it.
// - rc network mode drives output pin with clock divided by four.
// - rc gpio mode makes output pin port A bit 6.
// - external clock modes disable feedback device between oscillator pins.
// - external clock modes need at most 1.5 us start-up after reset or wake.
// - external clock mode drives output pin with clock divided by four.
// - external clock gpio mode makes output pin port A bit 6.
// - high-speed x4 mode multiplies oscillator frequency by four.
// - pll enabled only in high-speed x4 mode; otherwise clock comes direct.
// - pll state changes only at power-on reset or secondary oscillator round trip.
// - when pll engages, lock timer runs and execution is held until it expires.
// - pll lock timeout nominally 2 ms.
package oms_pkg;
    typedef enum logic [7:0] {
        OMS_LP   = 8'h01,
        OMS_XT   = 8'h02,
        OMS_HS   = 8'h04,
        OMS_HSX4 = 8'h08,
        OMS_RC   = 8'h10,
        OMS_RC_NETWORK_GPIO_MODE = 8'h20,
        OMS_EC   = 8'h40,
        OMS_EXT_CLOCK_GPIO_MODE = 8'h80
    } oms_mode_type;

    localparam int unsigned OMS_SEL_W      = 3;
    localparam int unsigned OMS_NUM_MODES  = 8;
    localparam int unsigned OMS_CLK_HZ     = 25000000;
    localparam int unsigned OMS_CLK_PS     = 40000;
    localparam int unsigned OMS_PLL_LOCK_TIMEOUT_US    = 2000;
    localparam int unsigned OMS_PLL_LOCK_TIMEOUT_CYC   = (OMS_PLL_LOCK_TIMEOUT_US * 1000000) / OMS_CLK_PS;
    localparam int unsigned OMS_EC_NS_X10  = 15;
    localparam int unsigned OMS_EC_CYC_RAW = (OMS_EC_NS_X10 * 100000) / OMS_CLK_PS;
    localparam int unsigned OMS_EC_CYC     = (OMS_EC_CYC_RAW < 1) ? 1 : OMS_EC_CYC_RAW;
    localparam int unsigned OMS_DIV        = 4;
    localparam logic [1:0]  OMS_DIV_RST    = 2'h0;
    // default code map: code n selects mode n in listed order
    localparam logic [23:0] OMS_MAP_DEF    = 24'hfac688;
endpackage : oms_pkg

// >>> rtl/oms_timer.sv
// down counter used for the start-up and pll lock waits
`timescale 1ns/1ps
module oms_timer #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             clk_i,   // system clock
    input  wire logic             rst_i,   // async reset
    input  wire logic             load_i,  // start a wait
    input  wire logic [WIDTH-1:0] count_i, // cycles to wait
    output logic                  busy_o   // wait in progress
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    // next count
    always_comb begin
        cnt_d = cnt_q;
        if (load_i) begin
            cnt_d = count_i;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - WIDTH'(1);
        end
    end

    // count register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy_o = load_i || (cnt_q != '0);
endmodule : oms_timer

// >>> tb/oms_properties.sv
// concurrent checks on the oscillator mode select ports
`timescale 1ns/1ps
module oms_properties #(
    parameter int unsigned PLL_LOCK_TIMEOUT_CYC = 20 // pll lock wait
) (
    input wire logic       clk_i,         // clock
    input wire logic       rst_i,         // reset
    input wire logic       sec_osc_sel_i, // secondary osc
    input wire logic       osc_out_pin_o, // output pin
    input wire logic       feedback_en_o, // feedback on
    input wire logic       pll_en_o,      // pll on
    input wire logic       exec_hold_o,   // hold
    input wire logic [7:0] mode_o         // mode
);
    import oms_pkg::*;
    logic [15:0] hold_cnt_q;
    logic        div_mode;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // divided clock modes and length of the current hold
    assign div_mode = mode_o[4] | mode_o[6];
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hold_cnt_q <= 16'h0;
        end else begin
            hold_cnt_q <= exec_hold_o ? hold_cnt_q + 16'h1 : 16'h0;
        end
    end
    sequence lock_hold_s;
        exec_hold_o [*8];
    endsequence
    mode_onehot_a: assert property ($onehot(mode_o)) else $error("mode not one-hot");
    mode_fixed_a: assert property (!exec_hold_o |=> $stable(mode_o)) else $error("mode moved");
    pll_mode_a: assert property (pll_en_o |-> mode_o == 8'h08) else $error("pll outside x4");
    feedback_off_a: assert property (|mode_o[7:4] |-> !feedback_en_o) else $error("feedback on");
    div_period_a: assert property (div_mode && $past(div_mode, 4) |-> osc_out_pin_o == $past(osc_out_pin_o, 4)
        && osc_out_pin_o != $past(osc_out_pin_o, 2)) else $error("pin not clock over four");
    pll_hold_a: assert property ($rose(pll_en_o) |-> lock_hold_s) else $error("run during lock");
    lock_length_a: assert property ($fell(exec_hold_o) && mode_o == 8'h08 |-> hold_cnt_q >= PLL_LOCK_TIMEOUT_CYC)
        else $error("lock wait short");
    sec_pll_a: assert property (sec_osc_sel_i |=> !pll_en_o) else $error("pll on secondary");
endmodule : oms_properties

// >>> tb/oms_ext_clk.sv
// external clock source on the oscillator input pin
`timescale 1ns/1ps
module oms_ext_clk (
    output logic clk_o // input pin
);
    // free-running source fitted in place of a crystal
    initial begin
        clk_o = 1'b0;
        forever #20 clk_o = ~clk_o;
    end
endmodule : oms_ext_clk

// >>> tb/testbench.sv
// self-checking bench for the oscillator mode select block
`timescale 1ns/1ps
module testbench;
    import oms_pkg::*;
    localparam int PLL_LOCK_TIMEOUT = 20;
    localparam int EC   = 1500 / 40;
    logic       clk_i, rst_i = 1, wake = 0, sec = 0, pa = 0, pa_oe = 0;
    logic [2:0] sel = 3'h0;
    logic       pin, pin_oe, pb, fb, pll, hold;
    logic [7:0] mode, q;
    int         n_fail = 0, comparisons = 0, n;
    oms_ext_clk osc (.clk_o(clk_i));
    oms_core #(.PLL_LOCK_TIMEOUT_CYC(PLL_LOCK_TIMEOUT)) uut (.clk_i(clk_i), .rst_i(rst_i), .osc_sel_field_i(sel), .wake_i(wake),
        .sec_osc_sel_i(sec), .port_a_bit6_i(pa), .port_a_bit6_oe_i(pa_oe), .osc_out_pin_o(pin),
        .osc_out_pin_oe_o(pin_oe), .port_a_bit6_o(pb), .feedback_en_o(fb), .pll_en_o(pll),
        .exec_hold_o(hold), .mode_o(mode));
    // compare and count
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task tick(input int k);
        repeat (k) @(negedge clk_i);
    endtask : tick
    // count cycles until execution is released
    task wait_hold;
        n = 0;
        while (hold !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
    endtask : wait_hold
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // one pass per mode code, field altered after capture
    initial begin
        for (int c = 0; c < 8; c++) begin
            rst_i = 1;
            sel = c[2:0];
            pa_oe = 0;
            tick(3);
            rst_i = 0;
            tick(1);
            sel = ~c[2:0];
            chk("mode", 8'h01 << c, mode);
            chk("pll", c == 3, pll);
            chk("feedback", c < 4, fb);
            chk("out enable", c == 4 || c == 6, pin_oe);
            wait_hold();
            chk("start wait", 1, c == 3 ? n >= PLL_LOCK_TIMEOUT - 2 && n <= PLL_LOCK_TIMEOUT + 4 : n <= (c > 5 ? EC + 4 : 4));
            chk("mode kept", 8'h01 << c, mode);
            if (c == 4 || c == 6) begin
                for (int i = 0; i < 8; i++) begin
                    q[i] = pin;
                    tick(1);
                end
                chk("div", 1, q[7:4] == q[3:0] && q[1:0] == ~q[3:2] && pin_oe);
            end
            if (c == 5 || c == 7) begin
                for (int b = 1; b >= 0; b--) begin
                    pa = b[0];
                    pa_oe = 1;
                    tick(2);
                    chk("port bit", {b[0], 1'b1, b[0]}, {pin, pin_oe, pb});
                end
            end
            if (c == 3) begin
                sec = 1;
                tick(2);
                chk("pll on secondary", 0, pll);
                sec = 0;
                tick(2);
                chk("pll back", 8'h03, {pll, hold});
                wait_hold();
            end
            if (c > 5) begin
                wake = 1;
                tick(1);
                wake = 0;
                tick(1);
                wait_hold();
                chk("wake wait", 1, n <= EC + 4);
            end
            $display("test mode %0d done", c);
        end
        final_report();
    end
    // cut a hang short
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
endmodule : testbench
bind oms_core oms_properties #(.PLL_LOCK_TIMEOUT_CYC(PLL_LOCK_TIMEOUT_CYC)) u_props (.clk_i(clk_i), .rst_i(rst_i),
    .sec_osc_sel_i(sec_osc_sel_i), .osc_out_pin_o(osc_out_pin_o), .feedback_en_o(feedback_en_o),
    .pll_en_o(pll_en_o), .exec_hold_o(exec_hold_o), .mode_o(mode_o));
